// ==== hdl/rfs_pkg.sv ====
package rfs_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_FAULT = 8'h08;
    localparam logic [7:0] OFS_CODE = 8'h0C;
    localparam logic [7:0] OFS_TXDATA = 8'h10;
    localparam logic [7:0] OFS_TXSTAT = 8'h14;
    localparam logic [7:0] OFS_TIMEOUT = 8'h18;
    localparam logic [7:0] OFS_RETRY = 8'h1C;
    // fault flag positions, lowest index has highest priority
    localparam int FLT_NUM = 15;
    localparam int FLT_PROGFLOW = 0;
    localparam int FLT_APPCS = 1;
    localparam int FLT_USERCS = 2;
    localparam int FLT_CONFIG = 3;
    localparam int FLT_VERSION = 4;
    localparam int FLT_SAFETY = 5;
    localparam int FLT_LINK = 6;
    localparam int FLT_ACK = 7;
    localparam int FLT_MSG = 8;
    localparam int FLT_FIELDCOMM = 9;
    localparam int FLT_COPROC = 10;
    localparam int FLT_PARSER = 11;
    localparam int FLT_USERLOGIC = 12;
    localparam int FLT_SBYPWR1 = 13;
    localparam int FLT_SBYPWR2 = 14;
    // option board fault shown only as status, not as a latched fault
    localparam logic [4:0] CODE_NONE = 5'h1F;
    // ctrl bits
    localparam int CTRL_SEND = 0;
    localparam int CTRL_LINKRST = 1;
    localparam int CTRL_CLEAR = 2;
    // resets and defaults
    localparam logic [15:0] TIMEOUT_RST = 16'h0400;
    localparam logic [3:0] RETRY_RST = 4'h3;
    localparam logic [15:0] CRC_POLY = 16'h1021;
    localparam logic [15:0] CRC_INIT = 16'hFFFF;
    localparam logic [7:0] SEQ_RST = 8'h00;
    // ack status codes from the standby
    localparam logic [1:0] RSP_ACK = 2'h1;
    localparam logic [1:0] RSP_ERR = 2'h2;
    typedef enum {TX_IDLE, TX_SEND, TX_WAIT, TX_DEAD} rfs_tx_t;
endpackage

// ==== hdl/rfs_crc16.sv ====
`timescale 1ns/1ps
module rfs_crc16
    import rfs_pkg::*;
(
    input wire logic [31:0] data,
    input wire logic [15:0] poly,
    output logic [15:0] crc
);
    // crc over a 32-bit word, msb first, seeded with CRC_INIT
    always_comb begin
        logic [15:0] c;
        c = CRC_INIT;
        for (int i = 31; i >= 0; i--) begin
            if (c[15] ^ data[i]) begin
                c = {c[14:0], 1'b0} ^ poly;
            end else begin
                c = {c[14:0], 1'b0};
            end
        end
        crc = c;
    end
endmodule

// ==== hdl/rfs_flag.sv ====
`timescale 1ns/1ps
module rfs_flag (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic cond,
    input wire logic clear,
    output logic flag
);
    logic flag_q;
    logic flag_d;
    // a set always wins over a clear; clear works only once cond is gone
    always_comb begin
        flag_d = flag_q;
        if (clear) begin
            flag_d = 1'b0;
        end
        if (cond) begin
            flag_d = 1'b1;
        end
    end
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
        end
    end
    assign flag = flag_q;
    a_flag_sticky: assert property ( // [R25]
        @(posedge ref_clk) disable iff (!rst_n)
        flag_q && !clear |=> flag_q)
        else $error("fault flag dropped without clear");
endmodule

// ==== hdl/rfs_supervisor.sv ====
`timescale 1ns/1ps
// Overview of operation
// [R1] Raise link fault whenever a problem is seen on the redundancy link.
// [R2] Link fault is shown whenever the standby controller is offline.
// [R3] Set version mismatch fault when firmware versions differ.
// [R4] Set safety rating mismatch when only one controller is safety rated.
// [R5] Master sends packets carrying a CRC and a transaction number.
// [R6] Standby checks the CRC, stores data, acks with same number.
// [R7] Master resends when no matching ack arrives before the timeout.
// [R8] After all retries, set ack fault and stop acknowledged traffic.
// [R9] Standby returns error message for good CRC with invalid content.
// [R10] Error message from standby sets the message fault flag.
// [R11] Field network fault when nothing arrives from the partner.
// [R12] Program flow fault and hand control over to the standby.
// [R13] Coprocessor fault raises the field network interface fault.
// [R14] User logic checksum mismatch raises user checksum fault.
// [R15] Firmware checksum against stored value, mismatch raises fault.
// [R16] Invalid or out of range user program data raises user logic fault.
// [R17] Unconfigured or corrupted configuration raises config fault.
// [R18] Parser fault when configuration read for the standby has errors.
// [R19] Report standby power input 1 and 2 as separate indications.
// [R20] Indicate a fault on the standby option board.
// [R21] Annunciate any fault and present the highest priority fault code.
// [R22] Hold the current fault and the most recent fault for readout.
// [R23] Indicate master or standby operating mode.
// [R24] Ack timeout, retry limit and CRC polynomial are configurable.
// [R25] Flags stay set until the condition clears and a clear is issued.
module rfs_supervisor
    import rfs_pkg::*;
#(
    parameter logic [15:0] CRC_POLYNOMIAL = CRC_POLY
)
(
    input wire logic ref_clk,
    input wire logic rst_n,
    // classic wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // redundancy link, master to standby
    output logic linkTxValid,
    output logic [31:0] linkTxData,
    output logic [7:0] linkTxSeq,
    output logic [15:0] linkTxCrc,
    // redundancy link, standby to master
    input wire logic linkRxValid,
    input wire logic [1:0] linkRxKind,
    input wire logic [7:0] linkRxSeq,
    input wire logic linkError,
    input wire logic standbyOnline,
    // fault sources
    input wire logic [7:0] localVersion,
    input wire logic [7:0] partnerVersion,
    input wire logic localSafetyRated,
    input wire logic partnerSafetyRated,
    input wire logic fieldPartnerSilent,
    input wire logic flowError,
    input wire logic coprocError,
    input wire logic [15:0] userSumCalc,
    input wire logic [15:0] userSumRef,
    input wire logic [15:0] appSumCalc,
    input wire logic [15:0] appSumStored,
    input wire logic userDataError,
    input wire logic configured,
    input wire logic configCorrupt,
    input wire logic parseError,
    input wire logic sbyPower1Ok,
    input wire logic sbyPower2Ok,
    input wire logic sbyOptionFault,
    input wire logic isPrimary,
    // outputs
    output logic faultActive,
    output logic [4:0] faultCode,
    output logic masterMode,
    output logic handover,
    output logic standbyOptionBoardFault
);
    typedef struct packed {
        rfs_tx_t txState;
        logic [31:0] txData;
        logic [7:0] seq;
        logic [15:0] crc;
        logic [15:0] timer;
        logic [3:0] tries;
        logic [15:0] timeoutCfg;
        logic [3:0] retryCfg;
        logic [4:0] lastCode;
        logic master;
        logic handover;
        logic ack;
        logic [31:0] rdata;
        logic msgErr;
        logic txPulse;
    } rfs_state_t;

    rfs_state_t s_q;
    rfs_state_t s_d;
    logic [FLT_NUM-1:0] cond;
    logic [FLT_NUM-1:0] flags;
    logic [15:0] crcNow;
    logic [4:0] code;
    logic wbReq;
    logic wbWr;
    logic clearPulse;
    logic ackMatch;
    logic ackFail;

    rfs_crc16 u_crc (
        .data(s_q.txData),
        .poly(CRC_POLYNOMIAL), // [R24]
        .crc(crcNow)
    );

    assign wbReq = wb_cyc_i && wb_stb_i && !s_q.ack;
    assign wbWr = wbReq && wb_we_i;
    assign clearPulse = wbWr && wb_adr_i == OFS_CTRL && wb_sel_i[0]
        && wb_dat_i[CTRL_CLEAR];
    assign ackMatch = linkRxValid && linkRxSeq == s_q.seq
        && s_q.txState == TX_WAIT;
    // a matching ack in the last cycle of the wait still wins
    assign ackFail = s_q.txState == TX_WAIT && s_q.timer == 16'h0000
        && s_q.tries >= s_q.retryCfg
        && !(ackMatch && linkRxKind == RSP_ACK);

    always_comb begin
        cond = '0;
        cond[FLT_LINK] = linkError || !standbyOnline; // [R1] [R2]
        cond[FLT_VERSION] = standbyOnline
            && localVersion != partnerVersion; // [R3]
        cond[FLT_SAFETY] = standbyOnline
            && localSafetyRated != partnerSafetyRated; // [R4]
        cond[FLT_ACK] = ackFail; // [R8]
        cond[FLT_MSG] = s_q.msgErr; // [R10]
        cond[FLT_FIELDCOMM] = fieldPartnerSilent; // [R11]
        cond[FLT_PROGFLOW] = flowError; // [R12]
        cond[FLT_COPROC] = coprocError; // [R13]
        cond[FLT_USERCS] = userSumCalc != userSumRef; // [R14]
        cond[FLT_APPCS] = appSumCalc != appSumStored; // [R15]
        cond[FLT_USERLOGIC] = userDataError; // [R16]
        cond[FLT_CONFIG] = !configured || configCorrupt; // [R17]
        cond[FLT_PARSER] = parseError; // [R18]
        cond[FLT_SBYPWR1] = standbyOnline && !sbyPower1Ok; // [R19]
        cond[FLT_SBYPWR2] = standbyOnline && !sbyPower2Ok; // [R19]
    end

    genvar g;
    generate
        for (g = 0; g < FLT_NUM; g++) begin : gFlag
            rfs_flag u_flag (
                .ref_clk(ref_clk),
                .rst_n(rst_n),
                .cond(cond[g]),
                .clear(clearPulse), // [R25]
                .flag(flags[g])
            );
        end
    endgenerate

    // priority encoder, lowest index wins
    always_comb begin
        code = CODE_NONE;
        for (int i = FLT_NUM - 1; i >= 0; i--) begin
            if (flags[i]) begin
                code = 5'(i); // [R21]
            end
        end
    end

    always_comb begin
        s_d = s_q;
        s_d.ack = wbReq;
        s_d.msgErr = linkRxValid && linkRxKind == RSP_ERR
            && s_q.master; // [R10]
        s_d.txPulse = 1'b0;
        if (code != CODE_NONE) begin
            s_d.lastCode = code; // [R22]
        end
        if (flags[FLT_PROGFLOW] && s_q.master) begin
            s_d.master = 1'b0; // [R12]
            s_d.handover = 1'b1;
        end
        // mode taken from the strap once reset is released
        if (!s_q.master && !s_q.handover && isPrimary) begin
            s_d.master = 1'b1; // [R23]
        end
        case (s_q.txState)
            TX_IDLE: begin
            end
            TX_SEND: begin
                s_d.crc = crcNow; // [R5]
                s_d.txPulse = 1'b1; // [R5]
                s_d.timer = s_q.timeoutCfg;
                s_d.txState = TX_WAIT;
            end
            TX_WAIT: begin
                if (ackMatch && linkRxKind == RSP_ACK) begin
                    s_d.txState = TX_IDLE;
                    s_d.seq = s_q.seq + 8'h01;
                end else if (s_q.timer != 16'h0000) begin
                    s_d.timer = s_q.timer - 16'h0001;
                end else if (s_q.tries < s_q.retryCfg) begin
                    s_d.tries = s_q.tries + 4'h1; // [R7]
                    s_d.txState = TX_SEND;
                end else begin
                    s_d.txState = TX_DEAD; // [R8]
                end
            end
            TX_DEAD: begin
            end
            default: begin
                s_d.txState = TX_IDLE;
            end
        endcase
        if (wbWr) begin
            case (wb_adr_i)
                OFS_CTRL: begin
                    if (wb_sel_i[0] && wb_dat_i[CTRL_SEND]
                        && s_q.txState == TX_IDLE && s_q.master) begin
                        s_d.txState = TX_SEND;
                        s_d.tries = 4'h0;
                    end
                    if (wb_sel_i[0] && wb_dat_i[CTRL_LINKRST]
                        && s_q.txState == TX_DEAD) begin
                        s_d.txState = TX_IDLE;
                    end
                end
                OFS_TXDATA: begin
                    for (int b = 0; b < 4; b++) begin
                        if (wb_sel_i[b] && s_q.txState == TX_IDLE) begin
                            s_d.txData[b*8 +: 8] = wb_dat_i[b*8 +: 8];
                        end
                    end
                end
                OFS_TIMEOUT: begin
                    if (wb_sel_i[0]) begin
                        s_d.timeoutCfg[7:0] = wb_dat_i[7:0]; // [R24]
                    end
                    if (wb_sel_i[1]) begin
                        s_d.timeoutCfg[15:8] = wb_dat_i[15:8];
                    end
                end
                OFS_RETRY: begin
                    if (wb_sel_i[0]) begin
                        s_d.retryCfg = wb_dat_i[3:0]; // [R24]
                    end
                end
                default: begin
                end
            endcase
        end
        s_d.rdata = 32'h00000000;
        if (wbReq && !wb_we_i) begin
            case (wb_adr_i)
                OFS_CTRL: s_d.rdata = 32'h00000000;
                OFS_STATUS: s_d.rdata = {24'h000000, sbyOptionFault,
                    sbyPower2Ok, sbyPower1Ok, standbyOnline, isPrimary,
                    s_q.handover, s_q.master, code != CODE_NONE};
                OFS_FAULT: s_d.rdata = {17'h00000, flags};
                OFS_CODE: s_d.rdata = {19'h00000, s_q.lastCode,
                    3'h0, code}; // [R22]
                OFS_TXDATA: s_d.rdata = s_q.txData;
                OFS_TXSTAT: s_d.rdata = {s_q.crc, s_q.seq, s_q.tries,
                    2'h0, 2'(s_q.txState)};
                OFS_TIMEOUT: s_d.rdata = {16'h0000, s_q.timeoutCfg};
                OFS_RETRY: s_d.rdata = {28'h0000000, s_q.retryCfg};
                default: s_d.rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q.txState <= TX_IDLE;
            s_q.txData <= 32'h00000000;
            s_q.seq <= SEQ_RST;
            s_q.crc <= 16'h0000;
            s_q.timer <= 16'h0000;
            s_q.tries <= 4'h0;
            s_q.timeoutCfg <= TIMEOUT_RST;
            s_q.retryCfg <= RETRY_RST;
            s_q.lastCode <= CODE_NONE;
            s_q.master <= 1'b0;
            s_q.handover <= 1'b0;
            s_q.ack <= 1'b0;
            s_q.rdata <= 32'h00000000;
            s_q.msgErr <= 1'b0;
            s_q.txPulse <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    assign wb_ack_o = s_q.ack;
    assign wb_dat_o = s_q.rdata;
    assign linkTxValid = s_q.txPulse; // [R5]
    assign linkTxData = s_q.txData;
    assign linkTxSeq = s_q.seq;
    assign linkTxCrc = s_q.crc;
    assign faultActive = code != CODE_NONE; // [R21]
    assign faultCode = code;
    assign masterMode = s_q.master; // [R23]
    assign handover = s_q.handover;
    assign standbyOptionBoardFault = sbyOptionFault; // [R20]

    a_retry_bound: assert property ( // [R7]
        @(posedge ref_clk) disable iff (!rst_n)
        s_q.tries <= s_q.retryCfg || s_q.txState == TX_IDLE)
        else $error("retry count beyond limit");
    a_timeout_resend: assert property ( // [R7]
        @(posedge ref_clk) disable iff (!rst_n)
        s_q.txState == TX_WAIT && s_q.timer == 16'h0000
        && s_q.tries < s_q.retryCfg && !linkRxValid |=> ##1 linkTxValid)
        else $error("packet not resent after timeout");
    a_dead_ackflag: assert property ( // [R8]
        @(posedge ref_clk) disable iff (!rst_n)
        s_q.txState == TX_WAIT && s_d.txState == TX_DEAD
        |=> flags[FLT_ACK])
        else $error("ack fault not set after retries");
    a_dead_silent: assert property ( // [R8]
        @(posedge ref_clk) disable iff (!rst_n)
        s_q.txState == TX_DEAD |-> !linkTxValid)
        else $error("sending after ack failure");
    a_link_error: assert property ( // [R1]
        @(posedge ref_clk) disable iff (!rst_n)
        linkError |=> flags[FLT_LINK])
        else $error("link problem not flagged");
    a_link_offline: assert property ( // [R2]
        @(posedge ref_clk) disable iff (!rst_n)
        !standbyOnline |=> flags[FLT_LINK])
        else $error("offline standby not flagged");
    a_msg_error: assert property ( // [R10]
        @(posedge ref_clk) disable iff (!rst_n)
        linkRxValid && linkRxKind == RSP_ERR && s_q.master
        |=> ##1 flags[FLT_MSG])
        else $error("error message not flagged");
    a_code_prio: assert property ( // [R21]
        @(posedge ref_clk) disable iff (!rst_n)
        flags[FLT_PROGFLOW] |-> faultCode == 5'h00)
        else $error("top priority fault not reported");
    a_flow_handover: assert property ( // [R12]
        @(posedge ref_clk) disable iff (!rst_n)
        flags[FLT_PROGFLOW] && s_q.master |=> !masterMode)
        else $error("control not handed over");
    a_wb_ackdrop: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held two cycles");
    a_resend_frame: assert property ( // [R5]
        @(posedge ref_clk) disable iff (!rst_n)
        s_q.txState == TX_SEND |=> linkTxValid && linkTxCrc == $past(crcNow))
        else $error("packet not sent with crc");
endmodule

// ==== test/rfs_standby_model.sv ====
`timescale 1ns/1ps
module rfs_standby_model
    import rfs_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [1:0] mode,
    input wire logic [3:0] delay,
    input wire logic txValid,
    input wire logic [31:0] txData,
    input wire logic [7:0] txSeq,
    input wire logic [15:0] txCrc,
    output logic rxValid,
    output logic [1:0] rxKind,
    output logic [7:0] rxSeq
);
    logic pending;
    logic [3:0] waitCnt;
    logic [7:0] seqHeld;
    logic [31:0] dataStore;
    function automatic logic [15:0] crcOf(input logic [31:0] d);
        logic [15:0] c;
        c = CRC_INIT;
        for (int i = 31; i >= 0; i--) begin
            c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? CRC_POLY : 16'h0000);
        end
        return c;
    endfunction
    // mode 0 proper ack, 1 ack with a wrong number, 2 error message
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pending <= 1'b0;
            waitCnt <= 4'h0;
            seqHeld <= 8'h00;
            dataStore <= 32'h00000000;
            rxValid <= 1'b0;
            rxKind <= 2'h0;
            rxSeq <= 8'h00;
        end else begin
            rxValid <= 1'b0;
            // idle response lines keep toggling so nothing stale is read
            rxKind <= ~rxKind;
            rxSeq <= ~rxSeq;
            if (txValid && crcOf(txData) == txCrc) begin
                pending <= 1'b1;
                waitCnt <= delay;
                seqHeld <= txSeq;
                dataStore <= txData;
            end else if (pending && waitCnt != 4'h0) begin
                waitCnt <= waitCnt - 4'h1;
            end else if (pending) begin
                pending <= 1'b0;
                rxValid <= 1'b1;
                rxKind <= (mode == 2'h2) ? RSP_ERR : RSP_ACK;
                rxSeq <= (mode == 2'h1) ? ~seqHeld : seqHeld;
            end
        end
    end
endmodule

// ==== test/tb_top.sv ====
`timescale 1ns/1ps
module tb_top
    import rfs_pkg::*;
;
    logic ref_clk, rst_n, wbCyc, wbStb, wbWe, wbAck, txValid, rxValid;
    logic [7:0] wbAdr, txSeq, rxSeq, partnerVersion;
    logic [3:0] wbSel, sbyDelay;
    logic [31:0] wbDatI, wbDatO, txData, rd;
    logic [15:0] txCrc, userSumCalc, appSumCalc;
    logic [1:0] rxKind, sbyMode;
    logic linkError, standbyOnline, partnerSafetyRated, fieldPartnerSilent;
    logic flowError, coprocError, userDataError, configured, configCorrupt;
    logic parseError, sbyPower1Ok, sbyPower2Ok, sbyOptionFault;
    logic faultActive, masterMode, handover, optFault;
    logic [4:0] faultCode;
    int n_errors, n_tests, pulses;
    int bitOf [15] = '{1, 2, 3, 3, 4, 5, 6, 6, 9, 10, 11, 12, 13, 14, 0};

    rfs_supervisor dut (.ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc_i(wbCyc),
        .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel),
        .wb_dat_i(wbDatI), .wb_dat_o(wbDatO), .wb_ack_o(wbAck),
        .linkTxValid(txValid), .linkTxData(txData), .linkTxSeq(txSeq),
        .linkTxCrc(txCrc), .linkRxValid(rxValid), .linkRxKind(rxKind),
        .linkRxSeq(rxSeq), .linkError(linkError),
        .standbyOnline(standbyOnline), .localVersion(8'h21),
        .partnerVersion(partnerVersion), .localSafetyRated(1'b1),
        .partnerSafetyRated(partnerSafetyRated),
        .fieldPartnerSilent(fieldPartnerSilent), .flowError(flowError),
        .coprocError(coprocError), .userSumCalc(userSumCalc),
        .userSumRef(16'hC3C3), .appSumCalc(appSumCalc),
        .appSumStored(16'h5A5A), .userDataError(userDataError),
        .configured(configured), .configCorrupt(configCorrupt),
        .parseError(parseError), .sbyPower1Ok(sbyPower1Ok),
        .sbyPower2Ok(sbyPower2Ok), .sbyOptionFault(sbyOptionFault),
        .isPrimary(1'b1), .faultActive(faultActive), .faultCode(faultCode),
        .masterMode(masterMode), .handover(handover),
        .standbyOptionBoardFault(optFault));
    rfs_standby_model sby (.ref_clk(ref_clk), .rst_n(rst_n), .mode(sbyMode),
        .delay(sbyDelay), .txValid(txValid), .txData(txData), .txSeq(txSeq),
        .txCrc(txCrc), .rxValid(rxValid), .rxKind(rxKind), .rxSeq(rxSeq));

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic wb(input logic we, input logic [7:0] a,
            input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= a;
        wbDatI <= d;
        // ack and read data are taken at the rising edge that shows ack
        do begin
            @(posedge ref_clk);
            n++;
        end while (wbAck !== 1'b1 && n < 50);
        if (n >= 50) chk(32'h0, 32'h1);
        rd = wbDatO;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        wbWe <= 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] m,
            input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(rd & m, e);
    endtask
    task automatic setc(input int k, input logic on);
        case (k)
            0: appSumCalc <= on ? 16'h1234 : 16'h5A5A;
            1: userSumCalc <= on ? 16'h0001 : 16'hC3C3;
            2: configured <= !on;
            3: configCorrupt <= on;
            4: partnerVersion <= on ? 8'h22 : 8'h21;
            5: partnerSafetyRated <= !on;
            6: linkError <= on;
            7: standbyOnline <= !on;
            8: fieldPartnerSilent <= on;
            9: coprocError <= on;
            10: parseError <= on;
            11: userDataError <= on;
            12: sbyPower1Ok <= !on;
            13: sbyPower2Ok <= !on;
            default: flowError <= on;
        endcase
    endtask
    // every packet on the link must carry the crc of its own data
    always @(negedge ref_clk) begin
        if (txValid === 1'b1) begin
            pulses++;
            chk(txCrc, sby.crcOf(txData));
        end
    end
    initial begin
        #100000;
        chk(32'h0, 32'h1);
        test_done();
    end
    initial begin
        {wbCyc, wbStb, wbWe, wbAdr, wbDatI, wbSel} = '0;
        {linkError, fieldPartnerSilent, flowError, coprocError} = '0;
        {userDataError, configCorrupt, parseError, sbyOptionFault} = '0;
        {standbyOnline, configured, sbyPower1Ok, sbyPower2Ok} = '1;
        partnerSafetyRated = 1'b1;
        partnerVersion = 8'h21;
        userSumCalc = 16'hC3C3;
        appSumCalc = 16'h5A5A;
        sbyMode = 2'h0;
        sbyDelay = 4'h2;
        wbSel = 4'hF;
        rst_n = 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        rdchk(OFS_TIMEOUT, 32'hFFFF, TIMEOUT_RST);
        rdchk(OFS_RETRY, 32'hF, RETRY_RST);
        rdchk(OFS_FAULT, 32'h7FFF, 32'h0);
        rdchk(OFS_CODE, 32'h1F, CODE_NONE);
        rdchk(OFS_STATUS, 32'h1F, 32'h1A);
        rdchk(8'hF0, 32'hFFFFFFFF, 32'h0);
        wb(1'b1, OFS_TIMEOUT, 32'h8);
        rdchk(OFS_TIMEOUT, 32'hFFFF, 32'h8);
        $display("register test done");
        pulses = 0;
        wb(1'b1, OFS_TXDATA, 32'hA5C31E0F);
        wb(1'b1, OFS_CTRL, 32'h1);
        repeat (10) @(posedge ref_clk);
        sbyDelay <= 4'h4;
        wb(1'b1, OFS_CTRL, 32'h1);
        repeat (12) @(posedge ref_clk);
        chk(pulses, 2);
        rdchk(OFS_TXSTAT, 32'hFF03, 32'h0200);
        chk(sby.dataStore, 32'hA5C31E0F);
        $display("link ack test done");
        sbyMode <= 2'h1;
        pulses = 0;
        wb(1'b1, OFS_RETRY, 32'h2);
        wb(1'b1, OFS_CTRL, 32'h1);
        repeat (80) @(posedge ref_clk);
        chk(pulses, 3);
        rdchk(OFS_TXSTAT, 32'h3, 32'h3);
        rdchk(OFS_FAULT, 32'h80, 32'h80);
        wb(1'b1, OFS_CTRL, 32'h1);
        repeat (20) @(posedge ref_clk);
        chk(pulses, 3);
        wb(1'b1, OFS_CTRL, 32'h2);
        rdchk(OFS_TXSTAT, 32'h3, 32'h0);
        sbyMode <= 2'h2;
        wb(1'b1, OFS_CTRL, 32'h1);
        repeat (8) @(posedge ref_clk);
        rdchk(OFS_FAULT, 32'h100, 32'h100);
        repeat (60) @(posedge ref_clk);
        wb(1'b1, OFS_CTRL, 32'h2);
        wb(1'b1, OFS_CTRL, 32'h4);
        rdchk(OFS_FAULT, 32'h7FFF, 32'h0);
        $display("link retry test done");
        sbyOptionFault <= 1'b1;
        repeat (2) @(posedge ref_clk);
        chk(optFault, 1'b1);
        rdchk(OFS_STATUS, 32'h80, 32'h80);
        sbyOptionFault <= 1'b0;
        rdchk(OFS_STATUS, 32'h80, 32'h0);
        for (int k = 0; k < 15; k++) begin
            setc(k, 1'b1);
            repeat (3) @(posedge ref_clk);
            chk(faultActive, 1'b1);
            chk(faultCode, bitOf[k]);
            rdchk(OFS_FAULT, 32'h7FFF, 1 << bitOf[k]);
            rdchk(OFS_CODE, 32'h1F, bitOf[k]);
            wb(1'b1, OFS_CTRL, 32'h4);
            rdchk(OFS_FAULT, 32'h7FFF, 1 << bitOf[k]);
            setc(k, 1'b0);
            repeat (2) @(posedge ref_clk);
            rdchk(OFS_FAULT, 32'h7FFF, 1 << bitOf[k]);
            wb(1'b1, OFS_CTRL, 32'h4);
            rdchk(OFS_CODE, 32'h1F1F, (bitOf[k] << 8) | 32'h1F);
        end
        chk({faultActive, faultCode}, {1'b0, CODE_NONE});
        chk({masterMode, handover}, 2'b01);
        rdchk(OFS_STATUS, 32'h6, 32'h4);
        $display("fault flag test done");
        test_done();
    end
endmodule
